// ### rtl/rtc_pkg.sv
/*
  Constants for the real-time clock status, prescaler and counter section:
  register offsets, field positions, reset values and timing counts.
  Assumes a 16-bit register port with byte offsets as addresses.
*/
package rtc_pkg;
  localparam logic [5:0] OFF_INT_ENABLE = 6'h00;
  localparam logic [5:0] OFF_CONTROL_STATUS_LOW = 6'h04;
  localparam logic [5:0] OFF_PRESCALE_RELOAD_HIGH = 6'h08;
  localparam logic [5:0] OFF_PRESCALE_RELOAD_LOW = 6'h0c;
  localparam logic [5:0] OFF_PRESCALE_DIVIDER_HIGH = 6'h10;
  localparam logic [5:0] OFF_PRESCALE_DIVIDER_LOW = 6'h14;
  localparam logic [5:0] OFF_TIME_COUNT_HIGH = 6'h18;
  localparam logic [5:0] OFF_TIME_COUNT_LOW = 6'h1c;
  localparam logic [5:0] OFF_ALARM_HIGH = 6'h20;
  localparam logic [5:0] OFF_ALARM_LOW = 6'h24;

  localparam int BIT_WRITE_DONE = 5;
  localparam int BIT_CONFIG_ENTRY = 4;
  localparam int BIT_ANY_REQUEST = 3;
  localparam int BIT_OVERFLOW_REQUEST = 2;
  localparam int BIT_ALARM_REQUEST = 1;
  localparam int BIT_TICK_REQUEST = 0;

  localparam logic [3:0] INT_ENABLE_RESET = 4'h0;
  localparam logic [19:0] PRESCALE_RELOAD_RESET = 20'h001ff;
  localparam logic [31:0] TIME_COUNT_RESET = 32'h0000_0000;
  localparam logic [31:0] ALARM_RESET = 32'hffff_ffff;

  localparam int FIXED_DIVIDE = 64;
  localparam logic [1:0] UPDATE_SLOW_CYCLES = 2'h3;

  // staged-write mask bit positions
  localparam int STAGE_CNT_HIGH = 0;
  localparam int STAGE_CNT_LOW = 1;
  localparam int STAGE_ALR_HIGH = 2;
  localparam int STAGE_ALR_LOW = 3;
  localparam int STAGE_PRL_HIGH = 4;
  localparam int STAGE_PRL_LOW = 5;
endpackage : rtc_pkg

// ### rtl/rtc_input_divider.sv
/*
  Slow input clock edge detector and fixed divide-by-64 stage.
  Assumes the slow clock is at least four times slower than i_clk and is
  already synchronous to it.
*/
`timescale 1ns/100ps
`default_nettype none
module rtc_input_divider (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_slow_input_clock,
  output logic o_slow_edge,
  output logic o_prescale_tick
);
  import rtc_pkg::*;

  typedef struct packed {
    logic armed;
    logic slow_prev;
    logic [5:0] count;
    logic slow_edge;
    logic prescale_tick;
  } div_state_type;

  div_state_type st;
  div_state_type next_st;

  always_comb begin
    next_st = st;
    // no false edge when the pin is already high as reset lifts
    next_st.armed = 1'b1;
    next_st.slow_prev = i_slow_input_clock;
    next_st.slow_edge = st.armed & i_slow_input_clock & ~st.slow_prev;
    next_st.prescale_tick = 1'b0;
    if (next_st.slow_edge) begin
      next_st.count = st.count + 6'h01;
      next_st.prescale_tick = (st.count == 6'(FIXED_DIVIDE - 1));
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_slow_edge = st.slow_edge;
  assign o_prescale_tick = st.prescale_tick;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  a_fixed_div_tick: assert property (
    o_prescale_tick |-> o_slow_edge && $past(st.count) == 6'h3f)
    else $error("divide-by-64 tick out of place");
endmodule : rtc_input_divider
`default_nettype wire

// ### rtl/rtc_core.sv
/*
  Real-time clock status, prescaler and time counter with register port.
  Assumes single-cycle register accesses on i_bus_select, 16-bit data, and
  a slow input clock sampled synchronously to i_clk.
*/
`timescale 1ns/100ps
`default_nettype none
module rtc_core (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_slow_input_clock,
  input wire logic i_bus_select,
  input wire logic i_bus_write,
  input wire logic [5:0] i_bus_addr,
  input wire logic [15:0] i_bus_wdata,
  output logic [15:0] o_bus_rdata,
  output logic o_irq_any,
  output logic o_irq_overflow,
  output logic o_irq_alarm,
  output logic o_irq_tick,
  output logic o_time_base_tick
);
  import rtc_pkg::*;

  typedef struct packed {
    logic [3:0] enable;
    logic config_entry_bit;
    logic write_done_flag;
    logic any_request_flag;
    logic overflow_request_flag;
    logic alarm_request_flag;
    logic tick_request_flag;
    logic [19:0] prescale_reload_value;
    logic [19:0] staged_reload;
    logic [19:0] divider;
    logic [31:0] time_count_value;
    logic [31:0] staged_count;
    logic [31:0] alarm;
    logic [31:0] staged_alarm;
    logic [5:0] staged_mask;
    logic [1:0] update_edges;
    logic [15:0] rdata;
    logic [3:0] irq;
    logic time_base_tick;
  } core_state_type;

  core_state_type st;
  core_state_type next_st;
  logic slow_edge;
  logic prescale_tick;

  rtc_input_divider input_divider (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_slow_input_clock(i_slow_input_clock),
    .o_slow_edge(slow_edge),
    .o_prescale_tick(prescale_tick)
  );

  // replace one 16-bit half of a 32-bit word
  function automatic logic [31:0] put_half(input logic [31:0] word,
                                           input logic high,
                                           input logic [15:0] data);
    put_half = high ? {data, word[15:0]} : {word[31:16], data};
  endfunction : put_half

  function automatic logic [15:0] pick_half(input logic [31:0] word,
                                            input logic high);
    pick_half = high ? word[31:16] : word[15:0];
  endfunction : pick_half

  logic bus_wr;
  logic bus_rd;
  logic writable;
  logic staging;
  logic [3:0] flag_clear;
  logic overflow_event;
  logic alarm_event;
  logic tick_event;
  logic [31:0] count_plus;

  always_comb begin
    next_st = st;
    bus_wr = i_bus_select & i_bus_write;
    bus_rd = i_bus_select & ~i_bus_write;
    writable = st.write_done_flag;
    staging = bus_wr & writable & st.config_entry_bit;
    flag_clear = 4'h0;
    count_plus = st.time_count_value + 32'h0000_0001;
    tick_event = 1'b0;
    overflow_event = 1'b0;
    alarm_event = 1'b0;

    // divider and time counter
    if (prescale_tick) begin
      if (st.divider == 20'h00000) begin
        tick_event = 1'b1;
        next_st.divider = st.prescale_reload_value;
        next_st.time_count_value = count_plus;
        overflow_event = (st.time_count_value == 32'hffff_ffff);
        alarm_event = (count_plus == st.alarm);
      end else begin
        next_st.divider = st.divider - 20'h00001;
      end
    end

    // register writes, all refused while an update is in flight
    if (bus_wr && writable) begin
      unique case (i_bus_addr)
        OFF_INT_ENABLE: next_st.enable = i_bus_wdata[3:0];
        OFF_CONTROL_STATUS_LOW: begin
          next_st.config_entry_bit = i_bus_wdata[BIT_CONFIG_ENTRY];
          flag_clear = ~i_bus_wdata[3:0];
          if (st.config_entry_bit && !i_bus_wdata[BIT_CONFIG_ENTRY]) begin
            next_st.write_done_flag = 1'b0;
            next_st.update_edges = 2'h0;
          end
        end
        default: ;
      endcase
    end
    if (staging) begin
      unique case (i_bus_addr)
        OFF_PRESCALE_RELOAD_HIGH: begin
          next_st.staged_reload[19:16] = i_bus_wdata[3:0];
          next_st.staged_mask[STAGE_PRL_HIGH] = 1'b1;
        end
        OFF_PRESCALE_RELOAD_LOW: begin
          next_st.staged_reload[15:0] = i_bus_wdata;
          next_st.staged_mask[STAGE_PRL_LOW] = 1'b1;
        end
        OFF_TIME_COUNT_HIGH: begin
          next_st.staged_count = put_half(st.staged_count, 1'b1,
                                          i_bus_wdata);
          next_st.staged_mask[STAGE_CNT_HIGH] = 1'b1;
        end
        OFF_TIME_COUNT_LOW: begin
          next_st.staged_count = put_half(st.staged_count, 1'b0,
                                          i_bus_wdata);
          next_st.staged_mask[STAGE_CNT_LOW] = 1'b1;
        end
        OFF_ALARM_HIGH: begin
          next_st.staged_alarm = put_half(st.staged_alarm, 1'b1,
                                          i_bus_wdata);
          next_st.staged_mask[STAGE_ALR_HIGH] = 1'b1;
        end
        OFF_ALARM_LOW: begin
          next_st.staged_alarm = put_half(st.staged_alarm, 1'b0,
                                          i_bus_wdata);
          next_st.staged_mask[STAGE_ALR_LOW] = 1'b1;
        end
        default: ;
      endcase
    end

    // update runs for three slow clock edges, then commits
    if (!st.write_done_flag && slow_edge) begin
      next_st.update_edges = st.update_edges + 2'h1;
      if (st.update_edges == UPDATE_SLOW_CYCLES - 2'h1) begin
        next_st.write_done_flag = 1'b1;
        next_st.staged_mask = 6'h00;
        if (st.staged_mask[STAGE_PRL_HIGH]) begin
          next_st.prescale_reload_value[19:16] = st.staged_reload[19:16];
        end
        if (st.staged_mask[STAGE_PRL_LOW]) begin
          next_st.prescale_reload_value[15:0] = st.staged_reload[15:0];
        end
        if (st.staged_mask[STAGE_CNT_HIGH]) begin
          next_st.time_count_value[31:16] = st.staged_count[31:16];
        end
        if (st.staged_mask[STAGE_CNT_LOW]) begin
          next_st.time_count_value[15:0] = st.staged_count[15:0];
        end
        if (st.staged_mask[STAGE_ALR_HIGH]) begin
          next_st.alarm[31:16] = st.staged_alarm[31:16];
        end
        if (st.staged_mask[STAGE_ALR_LOW]) begin
          next_st.alarm[15:0] = st.staged_alarm[15:0];
        end
        if (st.staged_mask[STAGE_PRL_HIGH] || st.staged_mask[STAGE_PRL_LOW]
            || st.staged_mask[STAGE_CNT_HIGH]
            || st.staged_mask[STAGE_CNT_LOW]) begin
          next_st.divider = {
            st.staged_mask[STAGE_PRL_HIGH] ? st.staged_reload[19:16]
                                           : st.prescale_reload_value[19:16],
            st.staged_mask[STAGE_PRL_LOW] ? st.staged_reload[15:0]
                                          : st.prescale_reload_value[15:0]
          };
        end
      end
    end

    // sticky request flags: a set in the clearing cycle wins
    next_st.tick_request_flag = tick_event
      | (st.tick_request_flag & ~flag_clear[BIT_TICK_REQUEST]);
    next_st.alarm_request_flag = alarm_event
      | (st.alarm_request_flag & ~flag_clear[BIT_ALARM_REQUEST]);
    next_st.overflow_request_flag = overflow_event
      | (st.overflow_request_flag & ~flag_clear[BIT_OVERFLOW_REQUEST]);
    next_st.any_request_flag = next_st.tick_request_flag
      | next_st.alarm_request_flag | next_st.overflow_request_flag
      | (st.any_request_flag & ~flag_clear[BIT_ANY_REQUEST]);

    next_st.irq = {next_st.any_request_flag, next_st.overflow_request_flag,
                   next_st.alarm_request_flag, next_st.tick_request_flag}
                  & next_st.enable;
    next_st.time_base_tick = tick_event;

    // read data, live values, reserved bits as zero
    if (bus_rd) begin
      unique case (i_bus_addr)
        OFF_INT_ENABLE: next_st.rdata = {12'h000, st.enable};
        OFF_CONTROL_STATUS_LOW: next_st.rdata = {10'h000,
          st.write_done_flag, st.config_entry_bit, st.any_request_flag,
          st.overflow_request_flag, st.alarm_request_flag,
          st.tick_request_flag};
        OFF_PRESCALE_RELOAD_HIGH:
          next_st.rdata = {12'h000, st.prescale_reload_value[19:16]};
        OFF_PRESCALE_RELOAD_LOW:
          next_st.rdata = st.prescale_reload_value[15:0];
        OFF_PRESCALE_DIVIDER_HIGH:
          next_st.rdata = {12'h000, st.divider[19:16]};
        OFF_PRESCALE_DIVIDER_LOW: next_st.rdata = st.divider[15:0];
        OFF_TIME_COUNT_HIGH:
          next_st.rdata = pick_half(st.time_count_value, 1'b1);
        OFF_TIME_COUNT_LOW:
          next_st.rdata = pick_half(st.time_count_value, 1'b0);
        default: next_st.rdata = 16'h0000;
      endcase
    end
  end

  // flags advance only on i_clk edges, so a stopped clock freezes them
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st <= '0;
      st.enable <= INT_ENABLE_RESET;
      st.write_done_flag <= 1'b1;
      st.prescale_reload_value <= PRESCALE_RELOAD_RESET;
      st.divider <= PRESCALE_RELOAD_RESET;
      st.time_count_value <= TIME_COUNT_RESET;
      st.alarm <= ALARM_RESET;
      st.staged_alarm <= ALARM_RESET;
      st.staged_reload <= PRESCALE_RELOAD_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign o_bus_rdata = st.rdata;
  assign o_irq_any = st.irq[3];
  assign o_irq_overflow = st.irq[2];
  assign o_irq_alarm = st.irq[1];
  assign o_irq_tick = st.irq[0];
  assign o_time_base_tick = st.time_base_tick;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  logic [1:0] busy_edges;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      busy_edges <= 2'h0;
    end else if (st.write_done_flag) begin
      busy_edges <= 2'h0;
    end else if (slow_edge && busy_edges != 2'h3) begin
      busy_edges <= busy_edges + 2'h1;
    end
  end

  sequence s_exit_config;
    i_bus_select && i_bus_write && i_bus_addr == OFF_CONTROL_STATUS_LOW
    && st.write_done_flag && st.config_entry_bit
    && !i_bus_wdata[BIT_CONFIG_ENTRY];
  endsequence
  sequence s_update_done;
    !st.write_done_flag ##1 st.write_done_flag;
  endsequence

  a_exit_starts_update: assert property (
    s_exit_config |=> !st.write_done_flag && !st.config_entry_bit)
    else $error("config exit did not start update");
  a_update_min_time: assert property (
    s_update_done |-> busy_edges == 2'h3 && $past(slow_edge))
    else $error("update finished before three slow edges");
  a_busy_blocks_reload: assert property (
    i_bus_select && i_bus_write && !st.write_done_flag
    && !slow_edge |=> $stable(st.prescale_reload_value)
    && $stable(st.staged_reload))
    else $error("reload changed during update");
  a_busy_blocks_enable: assert property (
    i_bus_select && i_bus_write && !st.write_done_flag |=> $stable(st.enable))
    else $error("enable written during update");
  a_tick_sets_flag: assert property (
    prescale_tick && st.divider == 20'h00000
    |=> st.tick_request_flag && o_time_base_tick)
    else $error("tick flag not set on terminal count");
  a_divider_reload: assert property (
    prescale_tick && st.divider == 20'h00000 && st.write_done_flag
    |=> st.divider == $past(st.prescale_reload_value)
    && st.time_count_value == $past(st.time_count_value) + 32'h1)
    else $error("divider or counter wrong at time-base tick");
  a_flag_one_keeps: assert property (
    st.alarm_request_flag && i_bus_select && i_bus_write
    && i_bus_addr == OFF_CONTROL_STATUS_LOW
    && i_bus_wdata[BIT_ALARM_REQUEST] |=> st.alarm_request_flag)
    else $error("writing one changed a request flag");
  a_any_follows: assert property (
    (st.tick_request_flag || st.alarm_request_flag
     || st.overflow_request_flag) |-> st.any_request_flag)
    else $error("any-request flag low with a request pending");
  a_irq_gated: assert property (
    o_irq_any |-> st.any_request_flag && st.enable[3])
    else $error("global interrupt without flag and enable");
  a_overflow_flag: assert property (
    prescale_tick && st.divider == 20'h00000
    && st.time_count_value == 32'hffff_ffff |=> st.overflow_request_flag)
    else $error("overflow flag not set on rollover");
endmodule : rtc_core
`default_nettype wire

// ### sim/rtc_status_prescaler_counter_bench.sv
/*
  Self-checking bench for rtc_core: register table loop, staged update,
  time-base flags, masking and a mid-run reset.
  Assumes the rtc_pkg package and the rtc_core module are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define check(got, exp) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, (got), (exp)); \
  end \
end
module rtc_status_prescaler_counter_bench;
  import rtc_pkg::*;
  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [15:0] wdata;
    logic [15:0] exp;
  } row_type;
  logic i_clk, i_reset_n, i_bus_select, i_bus_write;
  logic i_slow_input_clock = 1'b0;
  logic [5:0] i_bus_addr;
  logic [15:0] i_bus_wdata, o_bus_rdata, q;
  logic o_irq_any, o_irq_overflow, o_irq_alarm, o_irq_tick;
  logic o_time_base_tick, slow_run;
  logic [2:0] slow_div = 3'h0;
  int num_errors = 0;
  int checks_done = 0;
  row_type rows [0:18] = '{
    '{1'b0, 6'h00, 16'h0, 16'h0000}, '{1'b0, 6'h04, 16'h0, 16'h0020},
    '{1'b0, 6'h08, 16'h0, 16'h0000}, '{1'b0, 6'h0c, 16'h0, 16'h01ff},
    '{1'b0, 6'h10, 16'h0, 16'h0000}, '{1'b0, 6'h14, 16'h0, 16'h01ff},
    '{1'b0, 6'h18, 16'h0, 16'h0000}, '{1'b0, 6'h1c, 16'h0, 16'h0000},
    '{1'b0, 6'h20, 16'h0, 16'h0000}, '{1'b0, 6'h28, 16'h0, 16'h0000},
    '{1'b1, 6'h00, 16'h0005, 16'h0}, '{1'b0, 6'h00, 16'h0, 16'h0005},
    '{1'b1, 6'h00, 16'h0000, 16'h0}, '{1'b1, 6'h1c, 16'h5555, 16'h0},
    '{1'b0, 6'h1c, 16'h0, 16'h0000}, '{1'b1, 6'h14, 16'h0003, 16'h0},
    '{1'b0, 6'h14, 16'h0, 16'h01ff}, '{1'b1, 6'h0c, 16'h0007, 16'h0},
    '{1'b0, 6'h0c, 16'h0, 16'h01ff}};

  rtc_core dut_u (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_slow_input_clock(i_slow_input_clock),
    .i_bus_select(i_bus_select),
    .i_bus_write(i_bus_write),
    .i_bus_addr(i_bus_addr),
    .i_bus_wdata(i_bus_wdata),
    .o_bus_rdata(o_bus_rdata),
    .o_irq_any(o_irq_any),
    .o_irq_overflow(o_irq_overflow),
    .o_irq_alarm(o_irq_alarm),
    .o_irq_tick(o_irq_tick),
    .o_time_base_tick(o_time_base_tick)
  );

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // slow clock: eight main cycles a period, held while stopped
  always @(negedge i_clk) begin
    if (slow_run) begin
      slow_div <= slow_div + 3'h1;
      i_slow_input_clock <= slow_div[2];
    end
  end

  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out

  // one access: select held over the taking edge, data one cycle later
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [15:0] d, output logic [15:0] r);
    @(negedge i_clk);
    i_bus_select = 1'b1;
    i_bus_write = wr;
    i_bus_addr = a;
    i_bus_wdata = d;
    @(negedge i_clk);
    i_bus_select = 1'b0;
    @(negedge i_clk);
    r = o_bus_rdata;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    logic [15:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] r;
    bus(1'b0, a, 16'h0000, r);
    `check(r, exp)
  endtask : rd

  task automatic wait_tick;
    int n;
    n = 0;
    while (o_time_base_tick !== 1'b1 && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    if (n >= 2000) begin
      num_errors++;
      $display("MISMATCH t=%0t no time-base tick", $time);
    end
  endtask : wait_tick

  initial begin
    repeat (20000) @(posedge i_clk);
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end

  initial begin
    i_reset_n = 1'b0;
    i_bus_select = 1'b0;
    i_bus_write = 1'b0;
    i_bus_addr = 6'h00;
    i_bus_wdata = 16'h0000;
    slow_run = 1'b0;
    repeat (12) @(negedge i_clk);
    i_reset_n = 1'b1;
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].addr, rows[i].wdata, q);
      if (!rows[i].wr) `check(q, rows[i].exp)
    end
    // staged load: count just below rollover, alarm at zero
    wr(6'h04, 16'h0010);
    rd(6'h04, 16'h0030);
    wr(6'h18, 16'hffff);
    wr(6'h1c, 16'hfffe);
    wr(6'h20, 16'h0000);
    wr(6'h24, 16'h0000);
    wr(6'h08, 16'h0000);
    wr(6'h0c, 16'h0000);
    rd(6'h1c, 16'h0000);
    rd(6'h0c, 16'h01ff);
    wr(6'h04, 16'h000f);
    slow_run = 1'b1;
    repeat (2) @(posedge i_slow_input_clock);
    rd(6'h04, 16'h0000);
    wr(6'h00, 16'h000f);
    q = 16'h0000;
    for (int k = 0; k < 20 && q[5] !== 1'b1; k++) bus(1'b0, 6'h04, 16'h0, q);
    rd(6'h04, 16'h0020);
    rd(6'h00, 16'h0000);
    rd(6'h1c, 16'hfffe);
    rd(6'h18, 16'hffff);
    rd(6'h08, 16'h0000);
    rd(6'h0c, 16'h0000);
    rd(6'h14, 16'h0000);
    wr(6'h00, 16'h000f);
    wait_tick();
    `check({o_irq_any, o_irq_overflow, o_irq_alarm, o_irq_tick}, 4'h9)
    @(negedge i_clk);
    `check(o_time_base_tick, 1'b0)
    rd(6'h1c, 16'hffff);
    rd(6'h18, 16'hffff);
    rd(6'h04, 16'h0029);
    wr(6'h04, 16'h000e);
    rd(6'h04, 16'h0028);
    `check(o_irq_tick, 1'b0)
    wr(6'h00, 16'h000b);
    wait_tick();
    `check({o_irq_overflow, o_irq_tick}, 2'b01)
    `check(o_irq_alarm, 1'b1)
    slow_run = 1'b0;
    rd(6'h04, 16'h002f);
    rd(6'h1c, 16'h0000);
    rd(6'h18, 16'h0000);
    wr(6'h04, 16'h0007);
    rd(6'h04, 16'h002f);
    wr(6'h04, 16'h0000);
    rd(6'h04, 16'h0020);
    `check(o_irq_any, 1'b0)
    // second reset in mid-run
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_clk);
    `check({o_irq_any, o_irq_overflow, o_irq_alarm, o_irq_tick}, 4'h0)
    i_reset_n = 1'b1;
    rd(6'h04, 16'h0020);
    rd(6'h00, 16'h0000);
    rd(6'h0c, 16'h01ff);
    rd(6'h1c, 16'h0000);
    close_out();
  end
endmodule : rtc_status_prescaler_counter_bench
`default_nettype wire
